/* src/host_if_pkg.sv */
// Package: constants and types for the host interface select block
package host_if_pkg;

    // Interface variants chosen by the straps
    typedef enum logic [1:0] {
        IF_PAR80,
        IF_PAR68,
        IF_SER8,
        IF_SER9
    } iface_kind_e;

    // Strap codes {a,b,c}
    localparam logic [2:0] STRAP_P80_16 = 3'h7;
    localparam logic [2:0] STRAP_P80_8  = 3'h6;
    localparam logic [2:0] STRAP_P68_16 = 3'h4;
    localparam logic [2:0] STRAP_P68_8  = 3'h3;
    localparam logic [2:0] STRAP_SER9   = 3'h1;
    localparam logic [2:0] STRAP_SER8   = 3'h0;

    localparam int          DATA_W      = 16;
    localparam int          BYTE_W      = 8;
    localparam logic [3:0]  SER8_BITS   = 4'h8;
    localparam logic [3:0]  SER9_BITS   = 4'h9;
    localparam logic [3:0]  BITS_ZERO   = 4'h0;
    localparam logic [1:0]  SYNC_AGREE  = 2'h3;

    // Decoded transfer kinds
    typedef enum logic [1:0] {
        XF_CMD_WRITE,
        XF_DATA_WRITE,
        XF_STATUS_READ,
        XF_DATA_READ
    } xfer_kind_e;

    // Word handed to the core
    typedef struct packed {
        logic        isData;
        logic        wide;
        logic [15:0] word;
    } host_word_s;

    // Raw host pins
    typedef struct packed {
        logic        csN;
        logic        cmdDataSelect;
        logic        rdStrobe;
        logic        wrStrobe;
        logic        serData;
        logic        serClk;
        logic [15:0] dataIn;
    } host_pins_s;

endpackage

/* src/pin_sync3.sv */
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3
    import host_if_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
        end
        else
        begin
            stage1_r <= pinIn;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // Change accepted once the later stages agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : gAgree
            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                    pinOut[g] <= 1'b0;
                else if ({stage2_r[g], stage3_r[g]} == SYNC_AGREE || {stage2_r[g], stage3_r[g]} == 2'h0)
                    pinOut[g] <= stage3_r[g];
            end
        end
    endgenerate
endmodule // pin_sync3

/* src/mpu_host_interface_select.sv */
// Host bus interface: strap-selected parallel 80/68 or serial 8/9-bit port
// Summary of operation
// - Three static straps pick interface variant
// - Strap codes map to six interfaces
// - Serial data sampled on host serial clock
// - Selector high data, low command
// - 9-bit serial ignores selector pin
// - 9-bit serial: first bit marks data or command
// - Drive bus and capture words only while chip select low; read ack also fires when chip select ends a read
// - Deselected: bus released, controls ignored
// - 80-style read low drives bus
// - 68-style strobe is active-high enable
// - 80-style write captured on rising edge
// - 68-style direction: high read, low write
// - Selector and direction decode transfer kind
// - Low reset level initialises block
`timescale 1ns/1ps
module mpu_host_interface_select
    import host_if_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             ifaceStrapA,
    input  wire logic             ifaceStrapB,
    input  wire logic             ifaceStrapC,
    input  wire logic             resetNInput,
    input  wire host_pins_s       hostPins,
    input  wire logic [15:0]      readData,
    input  wire logic [15:0]      statusData,
    output logic [15:0]           dataOut,
    output logic [15:0]           dataOe,
    output host_word_s            wordOut,
    output logic                  wordValid,
    output logic                  dataReadAck,
    output logic                  coreReset,
    output logic [1:0]            ifaceKind,
    output logic                  busWide
);
    // =====================================================
    // Pin synchronisers
    // =====================================================
    localparam int SYNC_W = 8 + DATA_W;
    logic [SYNC_W-1:0] syncOut;
    logic              csN;
    logic              csSel;
    logic              cds;
    logic              rdS;
    logic              wrS;
    logic              sdi;
    logic              sck;
    logic              strA;
    logic              strB;
    logic              strC;
    logic              rstN;
    logic              rstLow;
    logic [15:0]       din;

    pin_sync3 #(.WIDTH(SYNC_W)) uSync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        // Chip select and reset enter inverted so the cleared stages read as idle
        .pinIn   ({!hostPins.csN, hostPins.cmdDataSelect, hostPins.rdStrobe, hostPins.wrStrobe,
                   hostPins.serData, hostPins.serClk, ifaceStrapA, ifaceStrapB, ifaceStrapC,
                   !resetNInput, hostPins.dataIn[13:0]}),
        .pinOut  (syncOut)
    );

    // The two top data bits ride a second narrow synchroniser
    logic [1:0] dinHi;
    pin_sync3 #(.WIDTH(2)) uSyncHi (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .pinIn   (hostPins.dataIn[15:14]),
        .pinOut  (dinHi)
    );

    assign {csSel, cds, rdS, wrS, sdi, sck, strA, strB, strC, rstLow} = syncOut[SYNC_W-1:14];
    assign csN  = !csSel;
    assign rstN = !rstLow;
    assign din = {dinHi, syncOut[13:0]};

    // =====================================================
    // Reset and strap capture
    // =====================================================
    logic        blkRst;
    logic [2:0]  strap_r;
    iface_kind_e kind_r;
    logic        wide_r;
    logic        rstSeen_r;
    logic [2:0]  settle_r;

    // Last settle count before the synchronised straps are valid
    localparam logic [2:0] SETTLE_LAST = 3'h4;

    assign blkRst = sys_rst || !rstN;

    // Straps caught while held in reset, frozen afterwards
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            strap_r   <= STRAP_SER8;
            rstSeen_r <= 1'b0;
            settle_r  <= '0;
        end
        else if (!rstN)
        begin
            strap_r   <= {strA, strB, strC};
            rstSeen_r <= 1'b1;
        end
        else if (!rstSeen_r)
        begin
            // Wait for the synchroniser to fill before trusting the straps
            settle_r <= settle_r + 3'h1;
            if (settle_r == SETTLE_LAST)
            begin
                strap_r   <= {strA, strB, strC};
                rstSeen_r <= 1'b1;
            end
        end
    end

    always_comb
    begin
        case (strap_r)
            STRAP_P80_16: begin kind_r = IF_PAR80; wide_r = 1'b1; end
            STRAP_P80_8:  begin kind_r = IF_PAR80; wide_r = 1'b0; end
            STRAP_P68_16: begin kind_r = IF_PAR68; wide_r = 1'b1; end
            STRAP_P68_8:  begin kind_r = IF_PAR68; wide_r = 1'b0; end
            STRAP_SER9:   begin kind_r = IF_SER9;  wide_r = 1'b0; end
            default:      begin kind_r = IF_SER8;  wide_r = 1'b0; end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            ifaceKind <= IF_SER8;
            busWide   <= 1'b0;
            coreReset <= 1'b1;
        end
        else
        begin
            ifaceKind <= kind_r;
            busWide   <= wide_r;
            coreReset <= !rstN;
        end
    end

    // =====================================================
    // Parallel decode
    // =====================================================
    logic       isPar;
    logic       rdActive;
    logic       wrActive;
    logic       wrPrev_r;
    logic       rdPrev_r;
    logic       sel;

    assign isPar = (kind_r == IF_PAR80) || (kind_r == IF_PAR68);
    assign sel   = !csN;

    // 80: separate low strobes; 68: high enable plus direction
    always_comb
    begin
        case (kind_r)
            IF_PAR80:
            begin
                rdActive = sel && !rdS;
                wrActive = sel && !wrS;
            end
            IF_PAR68:
            begin
                rdActive = sel && rdS && wrS;
                wrActive = sel && rdS && !wrS;
            end
            default:
            begin
                rdActive = 1'b0;
                wrActive = 1'b0;
            end
        endcase
    end

    function automatic xfer_kind_e decode_xfer(input logic selHi, input logic isRead);
        case ({selHi, isRead})
            2'h3:    decode_xfer = XF_DATA_READ;
            2'h2:    decode_xfer = XF_DATA_WRITE;
            2'h1:    decode_xfer = XF_STATUS_READ;
            default: decode_xfer = XF_CMD_WRITE;
        endcase
    endfunction

    always_ff @(posedge sys_clk)
    begin
        if (blkRst)
        begin
            wrPrev_r <= 1'b0;
            rdPrev_r <= 1'b0;
        end
        else
        begin
            wrPrev_r <= wrActive;
            rdPrev_r <= rdActive;
        end
    end

    // Bus drive: whole read interval, low byte only when narrow
    always_ff @(posedge sys_clk)
    begin
        if (blkRst || !isPar || !rdActive)
        begin
            dataOe  <= '0;
            dataOut <= '0;
        end
        else
        begin
            dataOut <= (decode_xfer(cds, 1'b1) == XF_DATA_READ) ? readData : statusData;
            dataOe  <= wide_r ? 16'hffff : 16'h00ff;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (blkRst)
            dataReadAck <= 1'b0;
        else
            dataReadAck <= rdPrev_r && !rdActive && isPar && cds;
    end

    // =====================================================
    // Serial shifter
    // =====================================================
    logic        sckPrev_r;
    logic [3:0]  bitCnt_r;
    logic [7:0]  shift_r;
    logic        frameCd_r;
    logic        isSer;
    logic        sckRise;
    logic [3:0]  frameBits;

    assign isSer     = (kind_r == IF_SER8) || (kind_r == IF_SER9);
    assign sckRise   = sck && !sckPrev_r;
    assign frameBits = (kind_r == IF_SER9) ? SER9_BITS : SER8_BITS;

    always_ff @(posedge sys_clk)
    begin
        if (blkRst)
            sckPrev_r <= 1'b0;
        else
            sckPrev_r <= sck;
    end

    // Deselect restarts the frame and drops a partial byte
    always_ff @(posedge sys_clk)
    begin
        if (blkRst || csN || !isSer)
        begin
            bitCnt_r  <= BITS_ZERO;
            shift_r   <= '0;
            frameCd_r <= 1'b0;
        end
        else if (sckRise)
        begin
            if (kind_r == IF_SER9 && bitCnt_r == BITS_ZERO)
                frameCd_r <= sdi;
            else
                shift_r <= {shift_r[6:0], sdi};
            bitCnt_r <= (bitCnt_r + 4'h1 == frameBits) ? BITS_ZERO : bitCnt_r + 4'h1;
        end
    end

    // =====================================================
    // Word output
    // =====================================================
    always_ff @(posedge sys_clk)
    begin
        if (blkRst)
        begin
            wordValid <= 1'b0;
            wordOut   <= '0;
        end
        else if (isPar && wrPrev_r && !wrActive && !csN)
        begin
            wordValid      <= 1'b1;
            wordOut.isData <= decode_xfer(cds, 1'b0) == XF_DATA_WRITE;
            wordOut.wide   <= wide_r;
            wordOut.word   <= wide_r ? din : {8'h00, din[7:0]};
        end
        else if (isSer && sckRise && !csN && bitCnt_r + 4'h1 == frameBits)
        begin
            wordValid      <= 1'b1;
            wordOut.isData <= (kind_r == IF_SER9) ? frameCd_r : cds;
            wordOut.wide   <= 1'b0;
            wordOut.word   <= {8'h00, shift_r[6:0], sdi};
        end
        else
            wordValid <= 1'b0;
    end

    // =====================================================
    // Checks
    // =====================================================
    a_bus_released: assert property (@(posedge sys_clk) disable iff (sys_rst)
        csN |=> dataOe == '0) else $error("bus driven while deselected");
    a_narrow_upper: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !wide_r |-> dataOe[15:8] == 8'h00) else $error("upper byte driven in narrow mode");
    a_read_drive: assert property (@(posedge sys_clk) disable iff (sys_rst || !rstN)
        rdActive && isPar |=> dataOe != '0) else $error("read strobe not driving bus");
    a_ser_no_bus: assert property (@(posedge sys_clk) disable iff (sys_rst)
        isSer |=> dataOe == '0) else $error("bus driven in serial mode");
    a_reset_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !rstN |=> !wordValid && coreReset) else $error("word during reset");
    a_write_edge: assert property (@(posedge sys_clk) disable iff (sys_rst || !rstN)
        kind_r == IF_PAR80 && $past(rstN) && !csN && $past(csN) == 1'b0 && $rose(wrS) |=> wordValid)
        else $error("write edge lost");
    a_ser9_flag: assert property (@(posedge sys_clk) disable iff (sys_rst || !rstN)
        kind_r == IF_SER9 && !csN && sckRise && bitCnt_r + 4'h1 == frameBits |=> wordOut.isData == $past(frameCd_r))
        else $error("9-bit frame flag wrong");
    a_desel_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        csN |=> !wordValid) else $error("word taken while deselected");
endmodule // mpu_host_interface_select

/* testbench/host_mpu_model.sv */
// Host processor model driving the parallel and serial host pins
`timescale 1ns/1ps
module host_mpu_model
    import host_if_pkg::*;
(
    input  wire logic  sys_clk,
    output host_pins_s pins
);
    // ==========
    // Idle pins
    initial pins = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0000};

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // ==========
    // Parallel cycle: start leaves the strobe active
    task automatic start(input logic m68, input logic rd, input logic dc, input logic [15:0] w, input logic sel);
        pins.rdStrobe = ~m68;
        pins.wrStrobe = 1'b1;
        tick(4);
        pins.csN = ~sel;
        pins.cmdDataSelect = dc;
        pins.wrStrobe = m68 ? rd : 1'b1;
        if (!rd)
            pins.dataIn = w;
        tick(5);
        if (m68)
            pins.rdStrobe = 1'b1;
        else if (rd)
            pins.rdStrobe = 1'b0;
        else
            pins.wrStrobe = 1'b0;
        tick(8);
    endtask

    task automatic finish(input logic m68);
        pins.rdStrobe = ~m68;
        if (!m68)
            pins.wrStrobe = 1'b1;
        tick(5);
        pins.wrStrobe = 1'b1;
        pins.csN = 1'b1;
        pins.dataIn = ~pins.dataIn;
        tick(5);
    endtask

    // ==========
    // Serial frame of n bits, flag bit first when nine
    task automatic ser(input logic nine, input logic dc, input logic [7:0] b, input int n);
        logic [8:0] f;
        f = {dc, b};
        pins.cmdDataSelect = nine ? ~dc : dc;
        pins.csN = 1'b0;
        tick(4);
        for (int i = 0; i < n; i++)
        begin
            pins.serData = f[(nine ? 8 : 7) - i];
            tick(4);
            pins.serClk = 1'b1;
            tick(4);
            pins.serClk = 1'b0;
        end
        tick(3);
        pins.serData = ~pins.serData;
        pins.csN = 1'b1;
        tick(5);
    endtask
endmodule // host_mpu_model

/* testbench/test_mpu_host_interface_select.sv */
// Self-checking bench for the strap-selected host interface
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module test_mpu_host_interface_select
    import host_if_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [2:0]  strap   = 3'h7;
    logic        resetN  = 1'b1;
    host_pins_s  pins;
    logic [15:0] dataOut, dataOe, rdData = 16'ha5c3, stData = 16'h3c5a;
    host_word_s  wordOut, got;
    logic        wordValid, dataReadAck, coreReset, busWide;
    logic [1:0]  ifaceKind;
    int          bad_count = 0, cmp_count = 0, nWords = 0, nAcks = 0, cycles = 0;

    always #50 sys_clk = ~sys_clk;

    host_mpu_model host (.sys_clk(sys_clk), .pins(pins));

    mpu_host_interface_select DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .ifaceStrapA(strap[2]),
        .ifaceStrapB(strap[1]), .ifaceStrapC(strap[0]), .resetNInput(resetN), .hostPins(pins),
        .readData(rdData), .statusData(stData), .dataOut(dataOut), .dataOe(dataOe), .wordOut(wordOut),
        .wordValid(wordValid), .dataReadAck(dataReadAck), .coreReset(coreReset), .ifaceKind(ifaceKind),
        .busWide(busWide));

    // ==========
    // Monitor and timeout
    always @(posedge sys_clk)
    begin
        cycles++;
        if (wordValid === 1'b1)
        begin
            got = wordOut;
            nWords++;
        end
        if (dataReadAck === 1'b1)
            nAcks++;
        if (cycles == 20000)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========
    // Scenarios
    task automatic mode(input logic [2:0] s, input logic [1:0] k, input logic w);
        strap = s;
        resetN = 1'b0;
        host.tick(8);
        `CHK(coreReset, 1'b1)
        resetN = 1'b1;
        host.tick(10);
        `CHK(coreReset, 1'b0)
        `CHK(ifaceKind, k)
        `CHK(busWide, w)
    endtask

    task automatic wr(input logic m68, input logic dc, input logic [15:0] w, input logic [15:0] m, input logic sel);
        int n0;
        n0 = nWords;
        host.start(m68, 1'b0, dc, w, sel);
        host.finish(m68);
        `CHK(nWords - n0, int'(sel))
        if (sel)
        begin
            `CHK(got.isData, dc)
            `CHK(got.word, w & m)
            `CHK(got.wide, m[15])
        end
    endtask

    task automatic rd(input logic m68, input logic dc, input logic [15:0] m, input logic sel);
        int n0;
        n0 = nAcks;
        host.start(m68, 1'b1, dc, 16'h0000, sel);
        `CHK(dataOe, sel ? m : 16'h0000)
        `CHK(dataOut & m & dataOe, (dc ? rdData : stData) & m & dataOe)
        host.finish(m68);
        `CHK(dataOe, 16'h0000)
        `CHK(nAcks - n0, int'(dc & sel))
    endtask

    task automatic srl(input logic nine, input logic dc, input logic [7:0] b, input int n, input int exp);
        int n0;
        n0 = nWords;
        host.ser(nine, dc, b, n);
        `CHK(nWords - n0, exp)
        if (exp == 1)
        begin
            `CHK(got.isData, dc)
            `CHK(got.word, 16'(b))
        end
    endtask

    // ==========
    // Main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        host.tick(6);
        mode(STRAP_P80_16, IF_PAR80, 1'b1);
        wr(1'b0, 1'b1, 16'hbeef, 16'hffff, 1'b1);
        wr(1'b0, 1'b0, 16'h002c, 16'hffff, 1'b1);
        rd(1'b0, 1'b1, 16'hffff, 1'b1);
        rd(1'b0, 1'b0, 16'hffff, 1'b1);
        wr(1'b0, 1'b1, 16'h1234, 16'hffff, 1'b0);
        rd(1'b0, 1'b1, 16'hffff, 1'b0);
        mode(STRAP_P80_8, IF_PAR80, 1'b0);
        wr(1'b0, 1'b1, 16'h77a5, 16'h00ff, 1'b1);
        rd(1'b0, 1'b1, 16'h00ff, 1'b1);
        mode(STRAP_P68_16, IF_PAR68, 1'b1);
        wr(1'b1, 1'b1, 16'hc0de, 16'hffff, 1'b1);
        wr(1'b1, 1'b0, 16'h0081, 16'hffff, 1'b1);
        rd(1'b1, 1'b1, 16'hffff, 1'b1);
        rd(1'b1, 1'b0, 16'hffff, 1'b1);
        mode(STRAP_P68_8, IF_PAR68, 1'b0);
        wr(1'b1, 1'b1, 16'h9e42, 16'h00ff, 1'b1);
        rd(1'b1, 1'b0, 16'h00ff, 1'b1);
        mode(STRAP_SER8, IF_SER8, 1'b0);
        srl(1'b0, 1'b1, 8'h96, 8, 1);
        srl(1'b0, 1'b0, 8'h3a, 8, 1);
        srl(1'b0, 1'b1, 8'hff, 4, 0);
        srl(1'b0, 1'b1, 8'h81, 8, 1);
        mode(STRAP_SER9, IF_SER9, 1'b0);
        srl(1'b1, 1'b1, 8'h5d, 9, 1);
        srl(1'b1, 1'b0, 8'hc2, 9, 1);
        report_and_stop();
    end
endmodule // test_mpu_host_interface_select
